// file: logic/sirc_pkg.sv
// constants, register map and state layout of the serial port control block
package sirc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [3:0] SIRC_CTRL_OFS   = 4'h0;   // serial_ctrl_reg
    localparam logic [3:0] SIRC_STATUS_OFS = 4'h4;   // serial_status_ctrl_reg
    localparam logic [3:0] SIRC_DATA_OFS   = 4'h8;   // serial_data_reg

    // serial_ctrl_reg fields
    localparam int SIRC_CTRL_PORT_EN = 0;
    localparam int SIRC_CTRL_MASTER  = 1;
    localparam int SIRC_CTRL_TX_IE   = 2;
    localparam int SIRC_CTRL_RX_IE   = 3;

    // serial_status_ctrl_reg fields
    localparam int SIRC_ST_RATE_LO   = 0;
    localparam int SIRC_ST_RATE_HI   = 1;
    localparam int SIRC_ST_DET_EN    = 2;
    localparam int SIRC_ST_TX_EMPTY  = 3;
    localparam int SIRC_ST_CONFLICT  = 4;
    localparam int SIRC_ST_OVERRUN   = 5;
    localparam int SIRC_ST_ERR_IE    = 6;
    localparam int SIRC_ST_RX_FULL   = 7;

    // ------------------------------------------------------------
    // transfer counts
    // ------------------------------------------------------------
    localparam logic [3:0] SIRC_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] SIRC_OVR_CHECK_CNT = 4'h6;  // captures before bit 1
    localparam logic [6:0] SIRC_HALF_DIV2     = 7'h00; // half bit minus one
    localparam logic [6:0] SIRC_HALF_DIV8     = 7'h03;
    localparam logic [6:0] SIRC_HALF_DIV32    = 7'h0f;
    localparam logic [6:0] SIRC_HALF_DIV128   = 7'h3f;

    // ------------------------------------------------------------
    // complete state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic       ack;        // bus answer pending this cycle
        logic       wreq;       // waitrequest, high while no answer stands
        logic [7:0] rdata;
        logic       port_en;    // port_enable_bit
        logic       master;
        logic       tx_ie;      // tx_irq_enable
        logic       rx_ie;      // rx_irq_enable
        logic       err_ie;     // error_irq_enable
        logic       det_en;     // select_conflict_detect_enable
        logic [1:0] rate;       // rate_select_hi, rate_select_lo
        logic       tx_empty;   // tx_empty_flag
        logic       rx_full;    // rx_full_flag
        logic       ovr;        // overrun_flag
        logic       conflict;   // select_conflict_flag
        logic       rx_armed;   // first step of receive clear done
        logic       ovr_armed;
        logic       conf_armed;
        logic [7:0] tx_buf;
        logic [7:0] rx_data;
        logic [7:0] shift;
        logic [3:0] bit_cnt;
        logic       busy;
        logic       ovr_hit;
        logic [6:0] div;
        logic       sck;
        logic       mosi;
        logic       miso;
        logic       sck_oe_n;
        logic       mosi_oe_n;
        logic       miso_oe_n;
        logic       irq_tx;
        logic       irq_rx;
        logic       sck_s1;
        logic       sck_s2;
        logic       sck_d;
        logic       ss_s1;
        logic       ss_s2;
        logic       din_m1;
        logic       din_m2;
        logic       din_s1;
        logic       din_s2;
    } sirc_state_s;

    localparam sirc_state_s SIRC_STATE_RST = '{
        master:    1'b1,
        wreq:      1'b1,
        tx_empty:  1'b1,
        sck_oe_n:  1'b1,
        mosi_oe_n: 1'b1,
        miso_oe_n: 1'b1,
        ss_s1:     1'b1,
        ss_s2:     1'b1,
        default:   '0
    };

endpackage

// file: logic/sirc_spi_ctrl.sv
// serial port control: interrupts, transmit queue, flags, resets, low power, break
//
// Functional notes
// - transmit request follows transmit-empty flag gated by its enable.
// - receive request needs receive-full, receive enable and port enabled.
// - overrun and select conflict request only with receive and error enables.
// - select conflict never sets while its detection is disabled.
// - receive-full sets whenever a finished byte reaches the receive register.
// - transmit-empty sets whenever a byte moves into the shift register.
// - data write queues the byte and clears transmit-empty.
// - status read with receive-full set, then data read, clears it.
// - master starts a queued byte right after the previous one ends.
// - slave with nothing queued resends what the shift register holds.
// - system reset returns every bit and flag to its reset value.
// - port disabled: empty set, transfer aborted, shifter and counter cleared, pins released.
// - disabling keeps control bits and receive, overrun, conflict flags.
// - master select conflict with detection enabled clears port enable.
// - in wait the port runs and requests wake; registers are inaccessible.
// - in stop activity halts with registers kept; reset exit resets port.
// - break without clear enable: accesses leave flags alone; armed clears survive.
// - break with clear enable: flags may clear and stay cleared.
// - data write in protected break does nothing at all.
// - unread data at bit 1 capture sets overrun and drops new byte.
// - master with detection enabled flags conflict when select goes low.
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
module sirc_spi_ctrl
    import sirc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire logic        wait_mode_i,
    input  wire logic        stop_mode_i,
    input  wire logic        break_i,
    input  wire logic        break_clear_enable_i,
    input  wire logic        sck_i,
    input  wire logic        ss_n_i,
    input  wire logic        mosi_i,
    input  wire logic        miso_i,
    output logic             sck_o,
    output logic             sck_oe_n_o,
    output logic             mosi_o,
    output logic             mosi_oe_n_o,
    output logic             miso_o,
    output logic             miso_oe_n_o,
    output logic             tx_irq_o,
    output logic             rx_irq_o
);

    // ------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------
    sirc_state_s q;
    sirc_state_s next_q;
    logic        acc;
    logic        clr_ok;
    logic        cap;
    logic        fall;
    logic        done;
    logic        din;

    // half bit time minus one for each rate setting
    // the fastest rate outruns the two-flop input path: a slave answering on the fall is late
    function automatic logic [6:0] half_limit(input logic [1:0] rate);
        case (rate)
            2'h0:    half_limit = SIRC_HALF_DIV2;
            2'h1:    half_limit = SIRC_HALF_DIV8;
            2'h2:    half_limit = SIRC_HALF_DIV32;
            default: half_limit = SIRC_HALF_DIV128;
        endcase
    endfunction

    // register read decode; all reads see zero in wait mode
    function automatic logic [7:0] read_value(input logic [3:0] addr, input sirc_state_s s,
                                              input logic blocked);
        logic [7:0] v;
        v = 8'h00;
        if (blocked) begin
            v = 8'h00;
        end else if (addr == SIRC_CTRL_OFS) begin
            v[SIRC_CTRL_PORT_EN] = s.port_en;
            v[SIRC_CTRL_MASTER]  = s.master;
            v[SIRC_CTRL_TX_IE]   = s.tx_ie;
            v[SIRC_CTRL_RX_IE]   = s.rx_ie;
        end else if (addr == SIRC_STATUS_OFS) begin
            v[SIRC_ST_RATE_HI:SIRC_ST_RATE_LO] = s.rate;
            v[SIRC_ST_DET_EN]   = s.det_en;
            v[SIRC_ST_TX_EMPTY] = s.tx_empty;
            v[SIRC_ST_CONFLICT] = s.conflict;
            v[SIRC_ST_OVERRUN]  = s.ovr;
            v[SIRC_ST_ERR_IE]   = s.err_ie;
            v[SIRC_ST_RX_FULL]  = s.rx_full;
        end else if (addr == SIRC_DATA_OFS) begin
            v = s.rx_data;
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        acc    = (read_i | write_i) & q.ack;
        clr_ok = ~break_i | break_clear_enable_i;
        cap    = 1'b0;
        fall   = 1'b0;
        done   = 1'b0;
        din    = 1'b0;

        // link inputs through two flops before use
        next_q.sck_s1 = sck_i;
        next_q.sck_s2 = q.sck_s1;
        next_q.sck_d  = q.sck_s2;
        next_q.ss_s1  = ss_n_i;
        next_q.ss_s2  = q.ss_s1;
        next_q.din_m1 = miso_i;
        next_q.din_m2 = q.din_m1;
        next_q.din_s1 = mosi_i;
        next_q.din_s2 = q.din_s1;

        // bus answer one cycle after the request is seen
        next_q.ack = (read_i | write_i) & ~q.ack;
        next_q.wreq = ~next_q.ack;                                      // own flop for the pin
        if (next_q.ack) begin
            next_q.rdata = read_value(address_i, q, wait_mode_i);
        end

        // register reads with side effects
        if (acc && read_i && !wait_mode_i && clr_ok) begin
            if (address_i == SIRC_STATUS_OFS) begin
                next_q.rx_armed   = q.rx_full;
                next_q.ovr_armed  = q.ovr;
                next_q.conf_armed = q.conflict;
            end else if (address_i == SIRC_DATA_OFS) begin
                if (q.rx_armed) begin
                    next_q.rx_full = 1'b0;
                end
                if (q.ovr_armed) begin
                    next_q.ovr = 1'b0;
                end
                next_q.rx_armed  = 1'b0;
                next_q.ovr_armed = 1'b0;
            end
        end

        // register writes
        if (acc && write_i && !wait_mode_i) begin
            if (address_i == SIRC_CTRL_OFS) begin
                next_q.port_en = writedata_i[SIRC_CTRL_PORT_EN];
                next_q.master  = writedata_i[SIRC_CTRL_MASTER];
                next_q.tx_ie   = writedata_i[SIRC_CTRL_TX_IE];
                next_q.rx_ie   = writedata_i[SIRC_CTRL_RX_IE];
                if (clr_ok && q.conf_armed) begin
                    next_q.conflict   = 1'b0;
                    next_q.conf_armed = 1'b0;
                end
            end else if (address_i == SIRC_STATUS_OFS) begin
                next_q.rate   = writedata_i[SIRC_ST_RATE_HI:SIRC_ST_RATE_LO];
                next_q.det_en = writedata_i[SIRC_ST_DET_EN];
                next_q.err_ie = writedata_i[SIRC_ST_ERR_IE];
            end else if (address_i == SIRC_DATA_OFS && clr_ok) begin
                next_q.tx_buf   = writedata_i[7:0];
                next_q.tx_empty = 1'b0;
            end
        end

        // serial engine, frozen in stop mode with all state kept
        if (stop_mode_i) begin
            next_q.div = q.div;
        end else if (!q.port_en) begin
            // partial reset; control bits and sticky flags stay
            next_q.tx_empty = 1'b1;
            next_q.busy     = 1'b0;
            next_q.shift    = 8'h00;
            next_q.bit_cnt  = 4'h0;
            next_q.div      = 7'h00;
            next_q.sck      = 1'b0;
            next_q.ovr_hit  = 1'b0;
        end else if (q.master) begin
            din = q.din_m2;
            if (q.det_en && !q.ss_s2) begin
                next_q.conflict = 1'b1;
                next_q.port_en  = 1'b0;
            end else if (!q.busy) begin
                if (!q.tx_empty) begin
                    next_q.shift    = q.tx_buf;
                    next_q.mosi     = q.tx_buf[7];
                    next_q.tx_empty = 1'b1;
                    next_q.busy     = 1'b1;
                    next_q.bit_cnt  = 4'h0;
                    next_q.div      = 7'h00;
                    next_q.ovr_hit  = 1'b0;
                end
            end else if (q.div == half_limit(q.rate)) begin
                next_q.div = 7'h00;
                next_q.sck = ~q.sck;
                cap        = ~q.sck;
                fall       = q.sck;
                done       = q.sck && (q.bit_cnt == SIRC_BITS_PER_BYTE);
            end else begin
                next_q.div = q.div + 7'h01;
            end
        end else begin
            din  = q.din_s2;
            cap  = ~q.ss_s2 & q.sck_s2 & ~q.sck_d;
            fall = ~q.ss_s2 & ~q.sck_s2 & q.sck_d;
            if (q.det_en && q.ss_s2 && q.bit_cnt != 4'h0) begin
                next_q.conflict = 1'b1;
            end
            if (q.bit_cnt == 4'h0 && !cap && !q.tx_empty) begin
                next_q.shift    = q.tx_buf;
                next_q.miso     = q.tx_buf[7];
                next_q.tx_empty = 1'b1;
                next_q.ovr_hit  = 1'b0;
            end
            // with nothing queued the shift register content goes out again
            done = cap && (q.bit_cnt == SIRC_BITS_PER_BYTE - 4'h1);
        end

        // shared capture and output shifting
        if (cap && q.bit_cnt != SIRC_BITS_PER_BYTE) begin
            next_q.shift   = {q.shift[6:0], din};
            next_q.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt == SIRC_OVR_CHECK_CNT) begin
                next_q.ovr_hit = q.rx_full;
            end
        end
        if (fall && !done) begin
            next_q.mosi = q.shift[7];
            next_q.miso = q.shift[7];
        end

        // end of byte: deliver or drop on overrun
        if (done) begin
            next_q.bit_cnt = 4'h0;
            next_q.busy    = 1'b0;
            if (q.ovr_hit) begin
                next_q.ovr = 1'b1;
            end else begin
                next_q.rx_data = next_q.shift;
                next_q.rx_full = 1'b1;
            end
        end

        // pin ownership; released to general I/O while disabled
        next_q.sck_oe_n  = ~(next_q.port_en & next_q.master);
        next_q.mosi_oe_n = ~(next_q.port_en & next_q.master);
        next_q.miso_oe_n = ~(next_q.port_en & ~next_q.master & ~q.ss_s2);

        // interrupt requests, also the wake source in wait mode
        next_q.irq_tx = next_q.tx_empty & next_q.tx_ie;
        next_q.irq_rx = next_q.rx_ie & ((next_q.port_en & next_q.rx_full)
                      | (next_q.err_ie & (next_q.ovr | next_q.conflict)));
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= SIRC_STATE_RST;
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from flops
    assign readdata_o    = {24'h000000, q.rdata};
    assign waitrequest_o = q.wreq;
    assign sck_o         = q.sck;
    assign sck_oe_n_o    = q.sck_oe_n;
    assign mosi_o        = q.mosi;
    assign mosi_oe_n_o   = q.mosi_oe_n;
    assign miso_o        = q.miso;
    assign miso_oe_n_o   = q.miso_oe_n;
    assign tx_irq_o      = q.irq_tx;
    assign rx_irq_o      = q.irq_rx;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_tx_irq_gate: assert property (
        (q.tx_empty && q.tx_ie) |-> tx_irq_o && $past(q.irq_tx || !q.tx_ie || !q.tx_empty))
        else $error("transmit request missing while empty and enabled");

    a_rx_irq_gate: assert property (
        !q.port_en && !(q.err_ie && (q.ovr || q.conflict)) |-> !rx_irq_o)
        else $error("receive request while port disabled");

    a_err_needs_rx: assert property (
        !q.rx_ie |-> !rx_irq_o)
        else $error("error request without receive enable");

    a_conflict_blocked: assert property (
        !q.det_en && !q.conflict |=> !q.conflict)
        else $error("conflict flag set with detection off");

    a_disable_reset: assert property (
        !q.port_en && !stop_mode_i |=> q.tx_empty && q.bit_cnt == 4'h0 && q.shift == 8'h00
                                      && !q.busy)
        else $error("partial reset incomplete");

    a_conflict_disables: assert property (
        q.port_en && q.master && q.det_en && !q.ss_s2 && !stop_mode_i
        |=> q.conflict && !q.port_en ##1 sck_oe_n_o)
        else $error("master conflict did not disable the port");

    a_break_protect: assert property (
        break_i && !break_clear_enable_i && q.rx_full |=> q.rx_full)
        else $error("flag cleared during protected break");

    a_break_write: assert property (
        acc && write_i && address_i == SIRC_DATA_OFS && break_i && !break_clear_enable_i
        |=> $stable(q.tx_buf))
        else $error("data write took effect during protected break");

    a_stop_freeze: assert property (
        stop_mode_i && q.port_en |=> $stable(q.shift) && $stable(q.bit_cnt))
        else $error("transfer moved during stop");

    a_bus_answer: assert property (
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("bus request not answered in one cycle");

    a_write_queues: assert property (
        acc && write_i && address_i == SIRC_DATA_OFS && clr_ok && !wait_mode_i && q.port_en
        && q.tx_empty |=> !q.tx_empty)
        else $error("data write did not clear transmit-empty");

    a_load_sets_empty: assert property (
        q.port_en && q.master && !q.busy && !q.tx_empty && !stop_mode_i
        && !(q.det_en && !q.ss_s2) |=> q.tx_empty && q.busy)
        else $error("queued byte not moved to the shift register");

    a_overrun_drops: assert property (
        done && q.ovr_hit |=> q.ovr && $stable(q.rx_data))
        else $error("overrun did not keep the unread byte");

endmodule

// file: dv/sirc_peer.sv
// serial peer model: slave to a master port, master to a slave port
`timescale 1ns/1ns
module sirc_peer (
    input  wire logic dut_sck_i,
    input  wire logic dut_mosi_i,
    input  wire logic dut_miso_i,
    input  wire logic sel_force_i,
    output logic      to_sck_o,
    output logic      to_mosi_o,
    output logic      to_miso_o,
    output logic      to_ss_n_o
);
    logic [7:0] sh_in;
    logic [7:0] cur;
    logic       ss_q;
    int         cnt;
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    // a forced select stands for a second master on the wire
    assign to_ss_n_o = ss_q & ~sel_force_i;
    initial begin
        to_sck_o = 1'b0;
        to_mosi_o = 1'b0;
        to_miso_o = 1'b0;
        ss_q = 1'b1;
        cnt = 0;
        cur = 8'h00;
    end
    // queue a byte to answer with; the first one waits on the line
    task automatic load(input logic [7:0] b);
        tx_q.push_back(b);
        if (tx_q.size() == 1) begin
            cur = b;
            to_miso_o = b[7];
        end
    endtask
    // as slave: capture on rise, msb first
    always @(posedge dut_sck_i) begin
        if (ss_q) begin
            sh_in = {sh_in[6:0], dut_mosi_i};
            cnt = cnt + 1;
        end
    end
    // as slave: shift on fall; the eighth fall ends the byte
    always @(negedge dut_sck_i) begin
        if (ss_q) begin
            if (cnt == 8) begin
                rx_q.push_back(sh_in);
                cnt = 0;
                void'(tx_q.pop_front());
                cur = (tx_q.size() != 0) ? tx_q[0] : ~cur;
            end
            to_miso_o = cur[3'(7 - cnt)];
        end
    end
    // as master: one frame of eight 80 ns clocks, clock still outside it
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        #3 ss_q = 1'b0;
        #80;
        for (int i = 7; i >= 0; i--) begin
            to_mosi_o = b[i];
            #50 to_sck_o = 1'b1;
            r = {r[6:0], dut_miso_i};
            #30 to_sck_o = 1'b0;
        end
        #80 ss_q = 1'b1;
        to_mosi_o = ~to_mosi_o; // released line shows no stale bit
    endtask
endmodule

// file: dv/sirc_spi_ctrl_test.sv
// self-checking bench of the serial port control block
`timescale 1ns/1ns
module sirc_spi_ctrl_test
    import sirc_pkg::*;
;
    localparam logic [3:0] C_CT = SIRC_CTRL_OFS;
    localparam logic [3:0] C_ST = SIRC_STATUS_OFS;
    localparam logic [3:0] C_DA = SIRC_DATA_OFS;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [3:0]  address_i = '0;
    logic        read_i = 1'b0;
    logic        write_i = 1'b0;
    logic [31:0] writedata_i = '0;
    logic        wait_mode_i = 1'b0;
    logic        stop_mode_i = 1'b0;
    logic        break_i = 1'b0;
    logic        break_clear_enable_i = 1'b0;
    logic        force_sel = 1'b0;
    logic [31:0] readdata_o;
    logic        waitrequest_o, tx_irq_o, rx_irq_o;
    logic        sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
    logic        p_sck, p_mosi, p_miso, p_ss_n;
    wire logic   sck_w, mosi_w, miso_w;
    int          n_fail = 0;
    int          tests_run = 0;
    int          m_rate = 0, m_det = 0, m_err = 0, m_txe = 1, m_rxf = 0, m_ovr = 0, m_conf = 0;
    // wire levels from the block's output enables; the peer drives each released wire
    assign sck_w = sck_oe_n_o ? p_sck : sck_o;
    assign mosi_w = mosi_oe_n_o ? p_mosi : mosi_o;
    assign miso_w = miso_oe_n_o ? p_miso : miso_o;
    always #5 clk_i = ~clk_i;
    sirc_spi_ctrl i_dut (.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .wait_mode_i(wait_mode_i),
        .stop_mode_i(stop_mode_i), .break_i(break_i), .break_clear_enable_i(break_clear_enable_i),
        .sck_i(sck_w), .ss_n_i(p_ss_n), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(sck_o),
        .sck_oe_n_o(sck_oe_n_o), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o),
        .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
    sirc_peer i_peer (.dut_sck_i(sck_w), .dut_mosi_i(mosi_w), .dut_miso_i(miso_w),
        .sel_force_i(force_sel), .to_sck_o(p_sck), .to_mosi_o(p_mosi), .to_miso_o(p_miso),
        .to_ss_n_o(p_ss_n));
    // model of the status register from the flag variables
    function automatic logic [31:0] exp_st();
        return 32'({m_rxf[0], m_err[0], m_ovr[0], m_conf[0], m_txe[0], m_det[0], m_rate[1:0]});
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        read_i <= ~wr;
        write_i <= wr;
        address_i <= a;
        writedata_i <= {24'h0, d};
        do @(posedge clk_i); while (waitrequest_o !== 1'b0);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, exp, what);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // wait until the peer holds k received bytes; a hang is ended by the watchdog
    task automatic wait_peer(input int k);
        while (i_peer.rx_q.size() < k) @(posedge clk_i);
        cyc(8);
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog: several times the longest run at the slowest rate
    initial begin
        #200_000;
        n_fail++;
        end_of_test();
    end
    // main sequence
    initial begin
        logic [31:0] q;
        logic [7:0]  d1, d2, p1, p2, r;
        void'($urandom(63694));
        cyc(3);
        reset_i <= 1'b0;
        rc(C_CT, 32'h02, "ctrl reset");
        rc(C_ST, exp_st(), "status reset");
        rc(4'hc, 32'h0, "unmapped read");
        chk({tx_irq_o, rx_irq_o}, 32'h0, "requests after reset");
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        p1 = 8'($urandom);
        p2 = 8'($urandom);
        m_rate = $urandom_range(3, 1); // fastest rate outruns the input synchronisers
        wr(C_ST, 8'(m_rate));
        wr(C_CT, 8'h0f);
        i_peer.load(p1);
        i_peer.load(p2);
        wr(C_DA, d1);
        wr(C_DA, d2);
        m_txe = 0;
        rc(C_ST, exp_st(), "byte queued");
        chk(tx_irq_o, 1'b0, "no transmit request while queued");
        wait_peer(2);
        m_txe = 1;
        m_rxf = 1;
        m_ovr = 1;
        rc(C_ST, exp_st(), "two bytes, second overran");
        chk(i_peer.rx_q[0], d1, "first byte on wire");
        chk(i_peer.rx_q[1], d2, "queued byte followed");
        chk({tx_irq_o, rx_irq_o}, 32'h3, "both requests");
        wr(C_CT, 8'h0e);
        rc(C_ST, exp_st(), "flags kept when disabled");
        rc(C_CT, 32'h0e, "control kept when disabled");
        chk({sck_oe_n_o, mosi_oe_n_o, miso_oe_n_o}, 32'h7, "pins released");
        chk({tx_irq_o, rx_irq_o}, 32'h2, "receive request off");
        m_err = 1;
        wr(C_ST, 8'(m_rate) | 8'h40);
        cyc(2);
        chk(rx_irq_o, 1'b1, "overrun request");
        m_err = 0;
        wr(C_ST, 8'(m_rate));
        cyc(2);
        chk(rx_irq_o, 1'b0, "overrun request masked");
        wr(C_CT, 8'h0f);
        rd(C_ST, q);
        break_i <= 1'b1;
        rc(C_DA, 32'(p1), "old byte readable");
        wr(C_DA, 8'h3c);
        cyc(40);
        chk(i_peer.rx_q.size(), 32'h2, "no transfer in break");
        rc(C_ST, exp_st(), "flags kept in break");
        break_i <= 1'b0;
        rc(C_DA, 32'(p1), "data after break");
        m_rxf = 0;
        m_ovr = 0;
        rc(C_ST, exp_st(), "second step clears");
        i_peer.load(p2);
        wr(C_DA, d1);
        wait_peer(3);
        chk(i_peer.rx_q[2], d1, "break write dropped");
        break_clear_enable_i <= 1'b1;
        break_i <= 1'b1;
        rd(C_ST, q);
        rc(C_DA, 32'(p2), "byte read in break");
        break_i <= 1'b0;
        break_clear_enable_i <= 1'b0;
        rc(C_ST, exp_st(), "cleared in break stays");
        wr(C_DA, d2);
        cyc(20);
        stop_mode_i <= 1'b1;
        cyc(300);
        chk(i_peer.rx_q.size(), 32'h3, "no progress in stop");
        stop_mode_i <= 1'b0;
        wait_peer(4);
        chk(i_peer.rx_q[3], d2, "transfer resumes after stop");
        rd(C_ST, q);
        rd(C_DA, q);
        force_sel <= 1'b1;
        cyc(10);
        rc(C_ST, exp_st(), "no conflict undetected");
        rc(C_CT, 32'h0f, "port stays on");
        m_det = 1;
        m_err = 1;
        m_conf = 1;
        wr(C_ST, 8'(m_rate) | 8'h44);
        cyc(10);
        rc(C_ST, exp_st(), "conflict flagged");
        rc(C_CT, 32'h0e, "conflict disables port");
        chk(rx_irq_o, 1'b1, "conflict request");
        force_sel <= 1'b0;
        m_det = 0;
        m_err = 0;
        m_conf = 0;
        wr(C_ST, 8'(m_rate));
        rd(C_ST, q);
        wr(C_CT, 8'h09);
        rc(C_ST, exp_st(), "conflict cleared");
        wr(C_DA, d2);
        i_peer.xfer(p1, r);
        chk(r, d2, "slave sends queued byte");
        cyc(10);
        rd(C_ST, q);
        rc(C_DA, 32'(p1), "slave receives");
        i_peer.xfer(p2, r);
        chk(r, p1, "slave resends shift contents");
        cyc(10);
        rd(C_ST, q);
        rd(C_DA, q);
        wait_mode_i <= 1'b1;
        rc(C_CT, 32'h0, "registers hidden in wait");
        wait_mode_i <= 1'b0;
        rc(C_CT, 32'h09, "registers back after wait");
        reset_i <= 1'b1;
        cyc(3);
        reset_i <= 1'b0;
        rc(C_CT, 32'h02, "ctrl after second reset");
        rc(C_ST, 32'h08, "status after second reset");
        end_of_test();
    end
endmodule
